// ---- logic/lbdc_device.sv ----
/*
 Dimming control logic of an eight-channel LED backlight driver: enable
 detection, idle shutdown, registers, mode select and the common dimming
 waveform. Assumes enable_dim_input is asynchronous; analog level arrives
 digitized on pclk.
*/
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
// Functional notes
// RQ1: First pulse enables only if long enough
// RQ2: Shut down after idle timeout
// RQ3: Host holds enable steady before dimming
// RQ4: On current follows DC level code
// RQ5: DC level any 8-bit, resets full
// RQ6: DC level applies immediately while running
// RQ7: DC level zero disconnects all channels
// RQ8: Brightness register 8-bit, resets full
// RQ9: Internal waveform 256 steps, brightness/255
// RQ10: Brightness zero disconnects all channels
// RQ11: Mode 0x05 register-only dimming
// RQ12: Mode 0x03 external pulse passes through
// RQ13: Mode 0x01 product dimming
// RQ14: Product duty equals external times brightness
// RQ15: Product mode after reset
// RQ16: All eight channels share one waveform
// RQ17: External duty limited by on/off times
// RQ18: Analog level scales duty down linearly
// RQ19: Internal frequency except in external mode
// RQ20: Analog level digitized, truncating multiplies
// RQ21: Register writes apply at next period
module lbdc_device
    import lbdc_pkg::*;
#(
    parameter int unsigned idle_timeout_cyc = lbdc_idle_timeout_cyc,
    parameter int unsigned dim_period_cyc = lbdc_dim_period_cyc,
    parameter int unsigned channels = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    lbdc_if.device link,
    input wire logic [7:0] analog_dim_level,
    output logic [channels-1:0] channel_on,
    output logic [7:0] channel_current,
    output logic enabled
);
    localparam logic [31:0] period_cyc = 32'(dim_period_cyc);
    localparam logic [31:0] idle_cyc = 32'(idle_timeout_cyc);
    localparam logic [31:0] qual_cyc = 32'(lbdc_enable_min_cyc);
    logic pin_s1_q, pin_s2_q, pin_prev_q;
    lbdc_state_e state_q;
    logic [31:0] width_q, idle_q, per_q, hi_q, ext_duty_q;
    logic [7:0] brt_q, dc_q, mode_q;
    logic [7:0] brt_act_q, mode_act_q;
    logic [7:0] ext8_q;
    logic [7:0] step_q;
    logic [7:0] duty_q;
    logic gate;
    logic per_end;
    logic [15:0] prod;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_prev_q <= 1'b0;
        end else if (clk_en) begin
            pin_s1_q <= link.enable_dim_input;
            pin_s2_q <= pin_s1_q;
            pin_prev_q <= pin_s2_q;
        end
    end

    // Enable qualification and idle shutdown
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= LBDC_OFF;
            width_q <= 32'h0;
            idle_q <= 32'h0;
        end else if (clk_en) begin
            case (state_q)
                LBDC_OFF: begin
                    width_q <= 32'h0;
                    if (pin_s2_q) state_q <= LBDC_QUAL;
                end
                LBDC_QUAL: begin
                    if (!pin_s2_q) state_q <= LBDC_OFF; // [RQ1]
                    else if (width_q + 32'h1 >= qual_cyc) state_q <= LBDC_RUN; // [RQ1]
                    width_q <= width_q + 32'h1;
                    idle_q <= 32'h0;
                end
                LBDC_RUN: begin
                    if (pin_s2_q) idle_q <= 32'h0;
                    else if (idle_q + 32'h1 > idle_cyc) state_q <= LBDC_OFF; // [RQ2]
                    else idle_q <= idle_q + 32'h1;
                end
                default: state_q <= LBDC_OFF;
            endcase
        end
    end

    // Registers; reset to full scale and product mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brt_q <= lbdc_rst_brightness; // [RQ8]
            dc_q <= lbdc_rst_dc_level; // [RQ5]
            mode_q <= lbdc_rst_mode; // [RQ15]
        end else if (clk_en && link.reg_wr) begin
            case (link.reg_addr)
                lbdc_off_brightness: brt_q <= link.reg_wdata;
                lbdc_off_dc_level: dc_q <= link.reg_wdata; // [RQ5]
                lbdc_off_mode: mode_q <= link.reg_wdata; // [RQ11] [RQ12] [RQ13]
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.reg_rdata <= 8'h00;
            link.reg_rvalid <= 1'b0;
        end else if (clk_en) begin
            link.reg_rvalid <= link.reg_rd;
            case (link.reg_addr)
                lbdc_off_brightness: link.reg_rdata <= brt_q;
                lbdc_off_dc_level: link.reg_rdata <= dc_q;
                lbdc_off_mode: link.reg_rdata <= mode_q;
                default: link.reg_rdata <= 8'h00;
            endcase
        end
    end

    // External duty measured over each external period as a 0..255 code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_duty_q <= 32'h0;
            hi_q <= 32'h0;
            ext8_q <= lbdc_full_code;
        end else if (clk_en) begin
            if (pin_s2_q && !pin_prev_q) begin
                ext_duty_q <= 32'h1;
                hi_q <= 32'h1;
                if (ext_duty_q != 32'h0)
                    ext8_q <= 8'((hi_q * 32'd255) / ext_duty_q); // [RQ20]
            end else begin
                if (ext_duty_q != 32'hffffffff) ext_duty_q <= ext_duty_q + 32'h1;
                if (pin_s2_q && hi_q != 32'hffffffff) hi_q <= hi_q + 32'h1;
            end
        end
    end

    // Internal dimming period: 256 steps of dim_period_cyc/256
    assign per_end = (per_q + 32'h1 >= period_cyc / 32'd256) && (step_q == 8'hff);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_q <= 32'h0;
            step_q <= 8'h00;
        end else if (clk_en) begin
            if (per_q + 32'h1 >= period_cyc / 32'd256) begin
                per_q <= 32'h0;
                step_q <= step_q + 8'h01; // [RQ9] [RQ19]
            end else begin
                per_q <= per_q + 32'h1;
            end
        end
    end

    // Latch settings at period start so no truncated pulse appears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brt_act_q <= lbdc_rst_brightness;
            mode_act_q <= lbdc_rst_mode;
            duty_q <= lbdc_full_code;
        end else if (clk_en && per_end) begin
            brt_act_q <= brt_q; // [RQ21]
            mode_act_q <= mode_q; // [RQ21]
            case (mode_q)
                lbdc_mode_product: duty_q <= prod[15:8]; // [RQ14]
                lbdc_mode_analog: duty_q <= 8'(({8'h00, brt_q} * {8'h00, 8'hff - analog_dim_level}) / 16'd255); // [RQ18]
                default: duty_q <= brt_q; // [RQ9] [RQ11]
            endcase
        end
    end
    // Truncating product, scaled by 256/255 to hit full scale exactly
    assign prod = 16'(({8'h00, brt_q} * {8'h00, ext8_q}) / 16'd255 * 16'd256 >> 0);

    always_comb begin
        if (mode_act_q == lbdc_mode_external) gate = pin_s2_q; // [RQ12] [RQ17]
        else gate = (duty_q == lbdc_full_code) || (step_q < duty_q); // [RQ9] [RQ19]
        if (brt_act_q == 8'h00) gate = 1'b0; // [RQ10]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_on <= '0;
            channel_current <= 8'h00;
            enabled <= 1'b0;
        end else if (clk_en) begin
            enabled <= (state_q == LBDC_RUN);
            channel_current <= (state_q == LBDC_RUN) ? dc_q : 8'h00; // [RQ4] [RQ6]
            // Zero current code counts as disconnected too
            channel_on <= {channels{gate && state_q == LBDC_RUN && dc_q != 8'h00}}; // [RQ7] [RQ16]
        end
    end
endmodule // lbdc_device

// ---- logic/lbdc_pkg.sv ----
/*
 Package for the LED backlight dimming control: register map, reset values,
 mode codes and timing constants. Assumes a 25 MHz pclk.
*/
package lbdc_pkg;
    localparam int unsigned lbdc_clk_hz = 25000000;
    localparam logic [7:0] lbdc_off_brightness = 8'h00;
    localparam logic [7:0] lbdc_off_mode = 8'h01;
    localparam logic [7:0] lbdc_off_dc_level = 8'h07;
    localparam logic [7:0] lbdc_rst_brightness = 8'hff;
    localparam logic [7:0] lbdc_rst_dc_level = 8'hff;
    localparam logic [7:0] lbdc_mode_product = 8'h01;
    localparam logic [7:0] lbdc_mode_external = 8'h03;
    localparam logic [7:0] lbdc_mode_register = 8'h05;
    localparam logic [7:0] lbdc_mode_analog = 8'h07;
    localparam logic [7:0] lbdc_rst_mode = 8'h01;
    localparam logic [7:0] lbdc_full_code = 8'hff;
    // Host APB register map
    localparam logic [7:0] lbdc_apb_ctrl = 8'h00;
    localparam logic [7:0] lbdc_apb_wdata = 8'h04;
    localparam logic [7:0] lbdc_apb_status = 8'h08;
    localparam logic [7:0] lbdc_apb_pulse = 8'h0c;
    // Times in their own units, cycle counts derived; the dimming period is given directly in cycles
    localparam int unsigned lbdc_enable_min_us = 40;
    localparam int unsigned lbdc_idle_timeout_ms = 28;
    localparam int unsigned lbdc_powerup_ms = 4;
    localparam int unsigned lbdc_enable_min_cyc = (lbdc_enable_min_us * (lbdc_clk_hz / 1000) + 999) / 1000;
    localparam int unsigned lbdc_idle_timeout_cyc = lbdc_idle_timeout_ms * (lbdc_clk_hz / 1000);
    localparam int unsigned lbdc_powerup_cyc = lbdc_powerup_ms * (lbdc_clk_hz / 1000);
    localparam int unsigned lbdc_dim_period_cyc = 100000;
    typedef enum logic [2:0] {
        LBDC_OFF = 3'b001,
        LBDC_QUAL = 3'b010,
        LBDC_RUN = 3'b100
    } lbdc_state_e;
endpackage // lbdc_pkg

// ---- logic/lbdc_if.sv ----
/*
 Link between the host end and the dimming device: the shared enable/dim pin
 and a simple one-cycle register write/read port standing for the SMBus
 transaction layer. Assumes both ends share pclk.
*/
`timescale 1ns/1ns
interface lbdc_if;
    logic enable_dim_input;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic reg_rvalid;
    modport device (
        input enable_dim_input, reg_wr, reg_rd, reg_addr, reg_wdata,
        output reg_rdata, reg_rvalid
    );
    modport host (
        output enable_dim_input, reg_wr, reg_rd, reg_addr, reg_wdata,
        input reg_rdata, reg_rvalid
    );
endinterface // lbdc_if

// ---- logic/lbdc_host.sv ----
/*
 Host end: APB slave with own registers that issues register writes/reads
 to the device and drives the shared enable/dim pin. Assumes pclk shared.
*/
`timescale 1ns/1ns
module lbdc_host
    import lbdc_pkg::*;
#(
    parameter int unsigned powerup_cyc = lbdc_powerup_cyc
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    lbdc_if.host link
);
    logic [31:0] pu_q;
    logic pin_req_q;
    logic [7:0] rd_q;
    logic busy_q;
    logic pu_done;
    logic acc;
    assign pu_done = (pu_q >= 32'(powerup_cyc));
    assign acc = psel && penable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link.reg_wr <= 1'b0;
            link.reg_rd <= 1'b0;
            link.reg_addr <= 8'h00;
            link.reg_wdata <= 8'h00;
            link.enable_dim_input <= 1'b0;
            pin_req_q <= 1'b0;
            pu_q <= 32'h0;
            rd_q <= 8'h00;
            busy_q <= 1'b0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else if (clk_en) begin
            link.reg_wr <= 1'b0;
            link.reg_rd <= 1'b0;
            pready <= 1'b0;
            // Once asked for, the pin is held high through the power-up enable interval,
            // so an early dimming request cannot cut the first enable pulse short
            if (!pu_done && (pin_req_q || pu_q != 32'h0)) pu_q <= pu_q + 32'h1;
            link.enable_dim_input <= pin_req_q || (pu_q != 32'h0 && !pu_done); // [RQ1] [RQ3]
            if (link.reg_rvalid) begin
                rd_q <= link.reg_rdata;
                busy_q <= 1'b0;
            end
            if (acc && !pready) begin
                pready <= 1'b1;
                pslverr <= 1'b0;
                prdata <= 32'h0;
                case (paddr)
                    lbdc_apb_ctrl: if (pwrite) begin
                        link.reg_addr <= pwdata[7:0];
                        link.reg_wr <= pwdata[8];
                        link.reg_rd <= pwdata[9];
                        busy_q <= pwdata[9];
                    end else prdata <= {22'h0, busy_q, 1'b0, link.reg_addr};
                    lbdc_apb_wdata: if (pwrite) link.reg_wdata <= pwdata[7:0];
                        else prdata <= {24'h0, link.reg_wdata};
                    lbdc_apb_status: prdata <= {22'h0, pu_done, busy_q, rd_q};
                    lbdc_apb_pulse: if (pwrite) pin_req_q <= pwdata[0];
                        else prdata <= {31'h0, pin_req_q};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end
endmodule // lbdc_host

// ---- tb/lbdc_assertions.sv ----
/*
 Checker on the host-device link and the device outputs.
 Assumes one pclk domain; the bench wires it by name.
*/
`timescale 1ns/1ns
module lbdc_assertions
    import lbdc_pkg::*;
#(
    parameter int unsigned idle_timeout_cyc = 200
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic enable_dim_input,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [7:0] channel_on,
    input wire logic [7:0] channel_current,
    input wire logic enabled
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic [15:0] hi_q;
    logic [15:0] lo_q;
    // Saturating, so a long spell never wraps into a short one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_q <= 16'h0000;
            lo_q <= 16'h0000;
        end else begin
            hi_q <= !enable_dim_input ? 16'h0000 : hi_q + {15'h0000, ~&hi_q};
            lo_q <= enable_dim_input ? 16'h0000 : lo_q + {15'h0000, ~&lo_q};
        end
    end
    sequence s_dc_write;
        reg_wr && reg_addr == lbdc_off_dc_level ##1 enabled [*3];
    endsequence
    a_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("read got no answer");
    a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd)) else $error("answer without read");
    a_one_request: assert property (!(reg_wr && reg_rd)) else $error("write and read together");
    a_lanes_common: assert property (channel_on == 8'h00 || channel_on == 8'hff)
        else $error("channels disagree");
    a_dark_disabled: assert property (!enabled [*3] |-> channel_on == 8'h00)
        else $error("channels on while disabled");
    a_enable_width: assert property ($rose(enabled) |-> hi_q >= 16'h03e8)
        else $error("enabled on a short pulse");
    a_idle_shutdown: assert property (lo_q == 16'(idle_timeout_cyc + 8) |-> !enabled)
        else $error("no shutdown after idle");
    a_dc_zero_dark: assert property (channel_current == 8'h00 [*3] |-> channel_on == 8'h00)
        else $error("channels on at zero current");
    a_dc_live: assert property (s_dc_write |-> channel_current == $past(reg_wdata, 3))
        else $error("current level not applied");
endmodule // lbdc_assertions

// ---- tb/lbdc_bench.sv ----
/*
 Bench: host and device joined by the link, host driven over APB.
 Assumes shortened counts: idle 200, period 512, powerup 100.
*/
`timescale 1ns/1ns
module lbdc_bench
    import lbdc_pkg::*;
;
    localparam int unsigned period = 512;
    logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00, analog_dim_level = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic pready, pslverr, slv, enabled;
    logic [7:0] channel_on, channel_current;
    int n_mismatch = 0, checked = 0;
    lbdc_if u_lbdc_if ();
    lbdc_host #(.powerup_cyc(100)) u_lbdc_host (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .link(u_lbdc_if));
    lbdc_device #(.idle_timeout_cyc(200), .dim_period_cyc(period), .channels(8)) u_lbdc_device (.pclk,
        .presetn, .clk_en, .link(u_lbdc_if), .analog_dim_level, .channel_on, .channel_current, .enabled);
    lbdc_assertions #(.idle_timeout_cyc(200)) u_lbdc_assertions (.pclk, .presetn, .channel_on,
        .channel_current, .enabled, .enable_dim_input(u_lbdc_if.enable_dim_input),
        .reg_wr(u_lbdc_if.reg_wr), .reg_rd(u_lbdc_if.reg_rd), .reg_addr(u_lbdc_if.reg_addr),
        .reg_wdata(u_lbdc_if.reg_wdata), .reg_rdata(u_lbdc_if.reg_rdata), .reg_rvalid(u_lbdc_if.reg_rvalid));
    task automatic give_verdict();
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bail(input string what);
        n_mismatch++;
        $display("BAD %s expected done seen timeout", what);
        give_verdict();
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Request held until pready is sampled high, then released
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) bail("pready");
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic poll(input int b, input logic v);
        int k;
        k = 0;
        do begin
            apb(1'b0, lbdc_apb_status, 32'h00000000);
            k++;
        end while (rd[b] !== v && k < 60);
        if (rd[b] !== v) bail("status");
    endtask
    // cmd[9:8] is 01 for a device write, 10 for a read
    task automatic dev(input logic [9:0] cmd, input logic [7:0] v);
        apb(1'b1, lbdc_apb_wdata, {24'h000000, v});
        apb(1'b1, lbdc_apb_ctrl, {22'h000000, cmd});
        poll(8, 1'b0);
    endtask
    task automatic pin(input logic v);
        apb(1'b1, lbdc_apb_pulse, {31'h00000000, v});
    endtask
    task automatic wait_en(input logic v, input int lim);
        for (int k = 0; k < lim && enabled !== v; k++) @(posedge pclk);
        if (enabled !== v) bail("enabled");
    endtask
    task automatic t_reset();
        logic [7:0] ad [3] = '{lbdc_off_brightness, lbdc_off_dc_level, lbdc_off_mode};
        logic [7:0] ex [3] = '{lbdc_rst_brightness, lbdc_rst_dc_level, lbdc_rst_mode};
        for (int i = 0; i < 3; i++) begin
            dev({2'b10, ad[i]}, 8'h00);
            chk("reset value", {8'h00, rd[7:0]}, {8'h00, ex[i]});
        end
        apb(1'b0, 8'h10, 32'h00000000);
        chk("unmapped", {15'h0000, slv}, 16'h0001);
        dev({2'b01, lbdc_off_dc_level}, 8'h5a);
        dev({2'b10, lbdc_off_dc_level}, 8'h00);
        chk("dc readback", {8'h00, rd[7:0]}, 16'h005a);
    endtask
    task automatic t_enable();
        pin(1'b1);
        pin(1'b0);
        chk("powerup hold", {15'h0000, u_lbdc_if.enable_dim_input}, 16'h0001);
        poll(9, 1'b1);
        cycles(20);
        chk("hold released", {15'h0000, u_lbdc_if.enable_dim_input}, 16'h0000);
        pin(1'b1);
        cycles(500);
        pin(1'b0);
        cycles(20);
        chk("short pulse", {15'h0000, enabled}, 16'h0000);
        pin(1'b1);
        cycles(990);
        chk("early enable", {15'h0000, enabled}, 16'h0000);
        wait_en(1'b1, 30);
        cycles(4);
        chk("on current", {8'h00, channel_current}, 16'h005a);
    endtask
    task automatic t_dc();
        dev({2'b01, lbdc_off_dc_level}, 8'h40);
        cycles(4);
        chk("dc live", {8'h00, channel_current}, 16'h0040);
        dev({2'b01, lbdc_off_dc_level}, 8'h00);
        cycles(4);
        chk("dc zero", {8'h00, channel_on}, 16'h0000);
        dev({2'b01, lbdc_off_dc_level}, 8'hff);
    endtask
    // Pin stays high, so the external duty plays no part here
    task automatic t_duty();
        logic [7:0] md [6] = '{8'h05, 8'h05, 8'h05, 8'h01, 8'h07, 8'h07};
        logic [7:0] br [6] = '{8'h00, 8'h80, 8'hff, 8'h00, 8'hff, 8'hff};
        logic [7:0] an [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
        int lo [6] = '{0, 254, 512, 0, 0, 512};
        int hi [6] = '{0, 260, 512, 0, 0, 512};
        int n;
        for (int i = 0; i < 6; i++) begin
            dev({2'b01, lbdc_off_mode}, md[i]);
            dev({2'b01, lbdc_off_brightness}, br[i]);
            analog_dim_level <= an[i];
            cycles(3 * period);
            n = 0;
            repeat (period) begin
                @(posedge pclk);
                n += int'(channel_on[0] === 1'b1);
            end
            chk("duty", {15'h0000, n >= lo[i] && n <= hi[i]}, 16'h0001);
        end
    endtask
    // Half-duty pulse train on the pin; internal waveform must carry that duty
    task automatic t_product();
        int n;
        dev({2'b01, lbdc_off_mode}, lbdc_mode_product);
        dev({2'b01, lbdc_off_brightness}, 8'hff);
        n = 0;
        fork
            repeat (4 * period / 8) begin
                pin(1'b1);
                pin(1'b0);
            end
            begin
                cycles(3 * period);
                repeat (period) begin
                    @(posedge pclk);
                    n += int'(channel_on[0] === 1'b1);
                end
            end
        join
        chk("product duty", {15'h0000, n >= 250 && n <= 260}, 16'h0001);
        pin(1'b1);
    endtask
    task automatic t_ext();
        dev({2'b01, lbdc_off_mode}, lbdc_mode_external);
        // Mode takes effect only at the next period end
        cycles(period + 8);
        for (int i = 0; i < 2; i++) begin
            pin(i[0]);
            cycles(8);
            chk("pass through", {8'h00, channel_on}, {8'h00, {8{i[0]}}});
        end
        dev({2'b01, lbdc_off_brightness}, 8'h00);
        cycles(period + 8);
        chk("ext dark", {8'h00, channel_on}, 16'h0000);
    endtask
    task automatic t_idle();
        pin(1'b0);
        cycles(150);
        chk("idle early", {15'h0000, enabled}, 16'h0001);
        wait_en(1'b0, 100);
        cycles(16);
        chk("stays off", {15'h0000, enabled}, 16'h0000);
    endtask
    initial begin
        forever #20 pclk = ~pclk;
    end
    initial begin
        repeat (100000) @(posedge pclk);
        bail("run");
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_enable();
        t_dc();
        t_duty();
        t_product();
        t_ext();
        t_idle();
        give_verdict();
    end
endmodule // lbdc_bench
